// ---- rtl/eip_arbiter.sv ----
`timescale 1ns/1ps

module eip_arbiter (
  // clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_i,
  // enabled pending sources and priority bits
  input  wire logic [eip_pkg::NUM_SRC-1:0] pend_i,
  input  wire logic [7:0]                  prio_lo_i,
  input  wire logic [7:0]                  prio_hi_i,
  // core handshake
  input  wire logic                        ack_i,
  input  wire logic                        reti_i,
  output eip_pkg::eip_irq_req_s            req_o,
  output logic [eip_pkg::NUM_LEVELS-1:0]   in_service_o
);

  eip_pkg::eip_irq_req_s                 req_r;
  eip_pkg::eip_irq_req_s                 req_nxt;
  logic [eip_pkg::NUM_LEVELS-1:0]        isr_r;
  logic [eip_pkg::NUM_LEVELS-1:0]        isr_nxt;
  logic [1:0]                            best_lvl;
  logic [3:0]                            best_idx;
  logic                                  found;
  logic [1:0]                            lvl;
  logic [1:0]                            top_lvl;
  logic                                  any_isr;
  logic                                  ack_hit;

  // ==========================================================================
  // selection and in-service tracking
  always_comb begin
    best_lvl = 2'h0;
    best_idx = 4'h0;
    found    = 1'b0;
    lvl      = 2'h0;
    top_lvl  = 2'h0;
    any_isr  = |isr_r;
    ack_hit  = ack_i & req_r.valid;
    // downward walk: higher level wins, lower index wins a tie
    for (int i = eip_pkg::NUM_SRC - 1; i >= 0; i--) begin
      lvl = eip_pkg::group_level(i, prio_lo_i, prio_hi_i);
      if (pend_i[i] && (!found || lvl >= best_lvl)) begin
        found    = 1'b1;
        best_lvl = lvl;
        best_idx = 4'(i);
      end
    end
    for (int l = 0; l < eip_pkg::NUM_LEVELS; l++) begin
      if (isr_r[l]) begin
        top_lvl = 2'(l);
      end
    end
    // only a strictly higher level breaks into a running handler
    req_nxt.valid  = found & (!any_isr || best_lvl > top_lvl) & ~ack_hit;
    req_nxt.src    = best_idx;
    req_nxt.level  = best_lvl;
    req_nxt.vector = eip_pkg::VECTOR_TABLE[best_idx];
    isr_nxt = isr_r;
    if (reti_i && any_isr) begin
      isr_nxt[top_lvl] = 1'b0;
    end
    if (ack_hit) begin
      isr_nxt[req_r.level] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_r <= '0;
      isr_r <= '0;
    end else begin
      req_r <= req_nxt;
      isr_r <= isr_nxt;
    end
  end

  assign req_o        = req_r;
  assign in_service_o = isr_r;

endmodule // eip_arbiter

// ---- rtl/eip_ctrl.sv ----
`timescale 1ns/1ps

module eip_ctrl #(
  parameter int CARD_W = 8,
  parameter int HOST_W = 3,
  parameter int MISC_W = 3
) (
  // clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        reset_i,
  // sfr access
  input  wire logic [7:0]                  sfr_addr_i,
  input  wire logic                        sfr_wr_i,
  input  wire logic [7:0]                  sfr_wdata_i,
  input  wire logic                        sfr_rd_i,
  output logic      [7:0]                  sfr_rdata_o,
  // core interrupt handshake
  output eip_pkg::eip_irq_req_s            irq_req_o,
  input  wire logic                        irq_ack_i,
  input  wire logic                        reti_i,
  output logic [eip_pkg::NUM_SRC-1:0]      irq_ack_src_o,
  output logic [eip_pkg::NUM_LEVELS-1:0]   in_service_o,
  // power down
  input  wire logic                        stop_i,
  output logic                             wake_o,
  // pins
  input  wire logic [7:0]                  user_io_pins_i,
  input  wire logic                        ext2_pin_i,
  input  wire logic                        ext3_pin_i,
  // user io interrupt control
  input  wire logic [7:0]                  user_io_hi_sel_i,
  input  wire logic [7:0]                  user_io_lo_sel_i,
  input  wire logic [7:0]                  user_io_pol_i,
  // timer and serial request flags
  input  wire logic                        tmr0_flag_i,
  input  wire logic                        tmr1_flag_i,
  input  wire logic                        ser0_flag_i,
  input  wire logic                        ser1_flag_i,
  // peripheral events, masks and per-source flags
  input  wire logic [CARD_W-1:0]           card_evt_i,
  input  wire logic [CARD_W-1:0]           card_mask_i,
  input  wire logic [HOST_W-1:0]           host_evt_i,
  input  wire logic [HOST_W-1:0]           host_mask_i,
  input  wire logic [MISC_W-1:0]           misc_evt_i,
  input  wire logic [MISC_W-1:0]           misc_mask_i,
  input  wire logic [2:0]                  src_flag_rd_i,
  output logic      [CARD_W-1:0]           card_flags_o,
  output logic      [HOST_W-1:0]           host_flags_o,
  output logic      [MISC_W-1:0]           misc_flags_o
);

  localparam int EVT_W = CARD_W + HOST_W + MISC_W;

  logic [7:0]        irq_en0_r;
  logic [7:0]        irq_en0_nxt;
  logic [7:0]        irq_en1_r;
  logic [7:0]        irq_en1_nxt;
  logic [7:0]        irq_en2_r;
  logic [7:0]        irq_en2_nxt;
  logic [7:0]        prio_low_r;
  logic [7:0]        prio_low_nxt;
  logic [7:0]        prio_high_r;
  logic [7:0]        prio_high_nxt;
  logic [7:0]        edge_sel_r;
  logic [7:0]        edge_sel_nxt;
  logic [3:0]        ext_type_r;
  logic [3:0]        ext_type_nxt;
  logic [4:0]        req_flag_r;
  logic [4:0]        req_flag_nxt;
  logic [CARD_W-1:0] card_flag_r;
  logic [CARD_W-1:0] card_flag_nxt;
  logic [HOST_W-1:0] host_flag_r;
  logic [HOST_W-1:0] host_flag_nxt;
  logic [MISC_W-1:0] misc_flag_r;
  logic [MISC_W-1:0] misc_flag_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;
  logic              wake_r;
  logic              wake_nxt;

  logic [9:0]                  pin_lvl;
  logic [9:0]                  pin_rise;
  logic [9:0]                  pin_fall;
  logic [EVT_W-1:0]            evt_rise;
  logic [4:0]                  line_lvl;
  logic [4:0]                  line_rise;
  logic [4:0]                  line_fall;
  logic                        ext0_line_n;
  logic                        ext1_line_n;
  logic [2:0]                  grp_line;
  logic [eip_pkg::NUM_SRC-1:0] pend;
  logic [eip_pkg::NUM_SRC-1:0] ack_vec;
  logic                        ack_hit;
  logic                        wr_type;
  logic                        wr_req;

  // ==========================================================================
  // input sampling and edge detection
  eip_sync_edge #(.W(10), .SYNC(1'b1), .IDLE(10'h300)) u_pins (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .d_i       ({ext3_pin_i, ext2_pin_i, user_io_pins_i}),
    .lvl_o     (pin_lvl),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // user io pins folded into two active-low lines after polarity
  assign ext0_line_n = ~|(user_io_hi_sel_i & (pin_lvl[7:0] ^ user_io_pol_i));
  assign ext1_line_n = ~|(user_io_lo_sel_i & (pin_lvl[7:0] ^ user_io_pol_i));

  // each line ORs its unmasked per-source flags
  assign grp_line[0] = |(card_flag_r & card_mask_i);
  assign grp_line[1] = |(host_flag_r & host_mask_i);
  assign grp_line[2] = |(misc_flag_r & misc_mask_i);

  eip_sync_edge #(.W(EVT_W), .SYNC(1'b0), .IDLE('0)) u_evts (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .d_i       ({misc_evt_i, host_evt_i, card_evt_i}),
    .lvl_o     (),
    .rise_o    (evt_rise),
    .fall_o    ()
  );

  eip_sync_edge #(.W(5), .SYNC(1'b0), .IDLE(5'h03)) u_lines (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .d_i       ({grp_line, ext1_line_n, ext0_line_n}),
    .lvl_o     (line_lvl),
    .rise_o    (line_rise),
    .fall_o    (line_fall)
  );

  // ==========================================================================
  // enabled requests and arbitration
  always_comb begin
    pend = '0;
    pend[eip_pkg::SRC_EXT0] = ext_type_r[eip_pkg::FLAG_EXT0]
                              & irq_en0_r[eip_pkg::EN0_EXT0];
    pend[eip_pkg::SRC_EXT1] = ext_type_r[eip_pkg::FLAG_EXT1]
                              & irq_en0_r[eip_pkg::EN0_EXT1];
    pend[eip_pkg::SRC_TMR0] = tmr0_flag_i & irq_en0_r[eip_pkg::EN0_TMR0];
    pend[eip_pkg::SRC_TMR1] = tmr1_flag_i & irq_en0_r[eip_pkg::EN0_TMR1];
    pend[eip_pkg::SRC_SER0] = ser0_flag_i & irq_en0_r[eip_pkg::EN0_SER0];
    pend[eip_pkg::SRC_SER1] = ser1_flag_i & irq_en2_r[eip_pkg::EN2_SER1];
    pend[eip_pkg::SRC_EXT2] = req_flag_r[0] & irq_en1_r[eip_pkg::EN1_EXT2];
    pend[eip_pkg::SRC_EXT3] = req_flag_r[1] & irq_en1_r[eip_pkg::EN1_EXT2 + 1];
    pend[eip_pkg::SRC_EXT4] = req_flag_r[2] & irq_en1_r[eip_pkg::EN1_EXT2 + 2];
    pend[eip_pkg::SRC_EXT5] = req_flag_r[3] & irq_en1_r[eip_pkg::EN1_EXT2 + 3];
    pend[eip_pkg::SRC_EXT6] = req_flag_r[4] & irq_en1_r[eip_pkg::EN1_EXT2 + 4];
    if (!irq_en0_r[eip_pkg::EN0_GLOBAL]) begin
      pend = '0;
    end
  end

  // low register bit 6 is kept for the watchdog but never reaches the arbiter
  eip_arbiter u_arb (
    .ref_clk_i    (ref_clk_i),
    .reset_i      (reset_i),
    .pend_i       (pend),
    .prio_lo_i    (prio_low_r & eip_pkg::PRIO_HI_WMASK),
    .prio_hi_i    (prio_high_r),
    .ack_i        (irq_ack_i),
    .reti_i       (reti_i),
    .req_o        (irq_req_o),
    .in_service_o (in_service_o)
  );

  assign ack_hit       = irq_ack_i & irq_req_o.valid;
  assign ack_vec       = ack_hit ? (eip_pkg::NUM_SRC'(1) << irq_req_o.src) : '0;
  assign irq_ack_src_o = ack_vec;

  // ==========================================================================
  // register and flag next state
  always_comb begin
    wr_type       = sfr_wr_i && sfr_addr_i == eip_pkg::EXT_TYPE_ADDR;
    wr_req        = sfr_wr_i && sfr_addr_i == eip_pkg::REQ_FLAG_ADDR;
    irq_en0_nxt   = irq_en0_r;
    irq_en1_nxt   = irq_en1_r;
    irq_en2_nxt   = irq_en2_r;
    prio_low_nxt  = prio_low_r;
    prio_high_nxt = prio_high_r;
    edge_sel_nxt  = edge_sel_r;
    ext_type_nxt  = ext_type_r;
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        eip_pkg::IRQ_EN0_ADDR:   irq_en0_nxt   = sfr_wdata_i & eip_pkg::IRQ_EN0_WMASK;
        eip_pkg::IRQ_EN1_ADDR:   irq_en1_nxt   = sfr_wdata_i & eip_pkg::IRQ_EN1_WMASK;
        eip_pkg::IRQ_EN2_ADDR:   irq_en2_nxt   = sfr_wdata_i & eip_pkg::IRQ_EN2_WMASK;
        eip_pkg::PRIO_LOW_ADDR:  prio_low_nxt  = sfr_wdata_i & eip_pkg::PRIO_LOW_WMASK;
        eip_pkg::PRIO_HIGH_ADDR: prio_high_nxt = sfr_wdata_i & eip_pkg::PRIO_HI_WMASK;
        eip_pkg::EDGE_SEL_ADDR:  edge_sel_nxt  = sfr_wdata_i & eip_pkg::EDGE_SEL_WMASK;
        eip_pkg::EXT_TYPE_ADDR: begin
          ext_type_nxt[eip_pkg::TYPE_EXT0] = sfr_wdata_i[eip_pkg::TYPE_EXT0];
          ext_type_nxt[eip_pkg::TYPE_EXT1] = sfr_wdata_i[eip_pkg::TYPE_EXT1];
        end
        default: ;
      endcase
    end
    // interrupts 0 and 1: edge mode latches, level mode follows the line
    if (ext_type_r[eip_pkg::TYPE_EXT0]) begin
      ext_type_nxt[eip_pkg::FLAG_EXT0] = eip_pkg::flag_next(
        ext_type_r[eip_pkg::FLAG_EXT0], line_fall[0], ack_vec[eip_pkg::SRC_EXT0],
        wr_type, sfr_wdata_i[eip_pkg::FLAG_EXT0]);
    end else begin
      ext_type_nxt[eip_pkg::FLAG_EXT0] = ~line_lvl[0];
    end
    if (ext_type_r[eip_pkg::TYPE_EXT1]) begin
      ext_type_nxt[eip_pkg::FLAG_EXT1] = eip_pkg::flag_next(
        ext_type_r[eip_pkg::FLAG_EXT1], line_fall[1], ack_vec[eip_pkg::SRC_EXT1],
        wr_type, sfr_wdata_i[eip_pkg::FLAG_EXT1]);
    end else begin
      ext_type_nxt[eip_pkg::FLAG_EXT1] = ~line_lvl[1];
    end
    // interrupts 2 and 3 from the dedicated pins
    req_flag_nxt[0] = eip_pkg::flag_next(req_flag_r[0],
      edge_sel_r[eip_pkg::EXT2_RISE] ? pin_rise[8] : pin_fall[8],
      ack_vec[eip_pkg::SRC_EXT2], wr_req, sfr_wdata_i[eip_pkg::REQ_FLAG_LSB]);
    req_flag_nxt[1] = eip_pkg::flag_next(req_flag_r[1],
      edge_sel_r[eip_pkg::EXT3_RISE] ? pin_rise[9] : pin_fall[9],
      ack_vec[eip_pkg::SRC_EXT3], wr_req, sfr_wdata_i[eip_pkg::REQ_FLAG_LSB + 1]);
    // interrupts 4..6 on the rising edge of their combined line
    req_flag_nxt[2] = eip_pkg::flag_next(req_flag_r[2], line_rise[2],
      ack_vec[eip_pkg::SRC_EXT4], wr_req, sfr_wdata_i[eip_pkg::REQ_FLAG_LSB + 2]);
    req_flag_nxt[3] = eip_pkg::flag_next(req_flag_r[3], line_rise[3],
      ack_vec[eip_pkg::SRC_EXT5], wr_req, sfr_wdata_i[eip_pkg::REQ_FLAG_LSB + 3]);
    req_flag_nxt[4] = eip_pkg::flag_next(req_flag_r[4], line_rise[4],
      ack_vec[eip_pkg::SRC_EXT6], wr_req, sfr_wdata_i[eip_pkg::REQ_FLAG_LSB + 4]);
    // per-source flags clear on read, a new event in that cycle survives
    card_flag_nxt = evt_rise[CARD_W-1:0] | (src_flag_rd_i[0] ? '0 : card_flag_r);
    host_flag_nxt = evt_rise[CARD_W+HOST_W-1:CARD_W]
                    | (src_flag_rd_i[1] ? '0 : host_flag_r);
    misc_flag_nxt = evt_rise[EVT_W-1:CARD_W+HOST_W]
                    | (src_flag_rd_i[2] ? '0 : misc_flag_r);
    // stop-state wake from interrupt 0 only
    wake_nxt = stop_i & irq_en0_r[eip_pkg::EN0_EXT0]
               & (~line_lvl[0] | ext_type_r[eip_pkg::FLAG_EXT0]);
    // read data, unmapped addresses read zero
    rdata_nxt = rdata_r;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        eip_pkg::IRQ_EN0_ADDR:   rdata_nxt = irq_en0_r;
        eip_pkg::IRQ_EN1_ADDR:   rdata_nxt = irq_en1_r;
        eip_pkg::IRQ_EN2_ADDR:   rdata_nxt = irq_en2_r;
        eip_pkg::PRIO_LOW_ADDR:  rdata_nxt = prio_low_r;
        eip_pkg::PRIO_HIGH_ADDR: rdata_nxt = prio_high_r;
        eip_pkg::EDGE_SEL_ADDR:  rdata_nxt = edge_sel_r;
        eip_pkg::EXT_TYPE_ADDR:  rdata_nxt = {4'h0, ext_type_r};
        eip_pkg::REQ_FLAG_ADDR:  rdata_nxt = {2'h0, req_flag_r, 1'b0};
        default:                 rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_en0_r   <= eip_pkg::SFR_RESET;
      irq_en1_r   <= eip_pkg::SFR_RESET;
      irq_en2_r   <= eip_pkg::SFR_RESET;
      prio_low_r  <= eip_pkg::SFR_RESET;
      prio_high_r <= eip_pkg::SFR_RESET;
      edge_sel_r  <= eip_pkg::SFR_RESET;
      ext_type_r  <= 4'h0;
      req_flag_r  <= 5'h00;
      card_flag_r <= '0;
      host_flag_r <= '0;
      misc_flag_r <= '0;
      rdata_r     <= 8'h00;
      wake_r      <= 1'b0;
    end else begin
      irq_en0_r   <= irq_en0_nxt;
      irq_en1_r   <= irq_en1_nxt;
      irq_en2_r   <= irq_en2_nxt;
      prio_low_r  <= prio_low_nxt;
      prio_high_r <= prio_high_nxt;
      edge_sel_r  <= edge_sel_nxt;
      ext_type_r  <= ext_type_nxt;
      req_flag_r  <= req_flag_nxt;
      card_flag_r <= card_flag_nxt;
      host_flag_r <= host_flag_nxt;
      misc_flag_r <= misc_flag_nxt;
      rdata_r     <= rdata_nxt;
      wake_r      <= wake_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign sfr_rdata_o  = rdata_r;
  assign wake_o       = wake_r;
  assign card_flags_o = card_flag_r;
  assign host_flags_o = host_flag_r;
  assign misc_flags_o = misc_flag_r;

endmodule // eip_ctrl

// ---- rtl/eip_pkg.sv ----
package eip_pkg;

  // ==========================================================================
  // sfr addresses
  localparam logic [7:0] EXT_TYPE_ADDR  = 8'h88;
  localparam logic [7:0] IRQ_EN2_ADDR   = 8'h9A;
  localparam logic [7:0] IRQ_EN0_ADDR   = 8'hA8;
  localparam logic [7:0] PRIO_LOW_ADDR  = 8'hA9;
  localparam logic [7:0] IRQ_EN1_ADDR   = 8'hB8;
  localparam logic [7:0] PRIO_HIGH_ADDR = 8'hB9;
  localparam logic [7:0] REQ_FLAG_ADDR  = 8'hC0;
  localparam logic [7:0] EDGE_SEL_ADDR  = 8'hC8;

  // ==========================================================================
  // reset value and implemented bits
  localparam logic [7:0] SFR_RESET      = 8'h00;
  localparam logic [7:0] IRQ_EN0_WMASK  = 8'hDF;
  localparam logic [7:0] IRQ_EN1_WMASK  = 8'h7E;
  localparam logic [7:0] IRQ_EN2_WMASK  = 8'h01;
  localparam logic [7:0] PRIO_LOW_WMASK = 8'h7F;
  localparam logic [7:0] PRIO_HI_WMASK  = 8'h3F;
  localparam logic [7:0] EDGE_SEL_WMASK = 8'h60;

  // ==========================================================================
  // bit positions
  localparam int EN0_GLOBAL   = 7;
  localparam int EN0_SER0     = 4;
  localparam int EN0_TMR1     = 3;
  localparam int EN0_EXT1     = 2;
  localparam int EN0_TMR0     = 1;
  localparam int EN0_EXT0     = 0;
  localparam int EN1_EXT2     = 1;
  localparam int EN2_SER1     = 0;
  localparam int TYPE_EXT0    = 0;
  localparam int FLAG_EXT0    = 1;
  localparam int TYPE_EXT1    = 2;
  localparam int FLAG_EXT1    = 3;
  localparam int EXT2_RISE    = 5;
  localparam int EXT3_RISE    = 6;
  localparam int REQ_FLAG_LSB = 1;

  // ==========================================================================
  // source indices, also the fixed polling order
  localparam int SRC_EXT0   = 0;
  localparam int SRC_SER1   = 1;
  localparam int SRC_TMR0   = 2;
  localparam int SRC_EXT2   = 3;
  localparam int SRC_EXT1   = 4;
  localparam int SRC_EXT3   = 5;
  localparam int SRC_TMR1   = 6;
  localparam int SRC_EXT4   = 7;
  localparam int SRC_SER0   = 8;
  localparam int SRC_EXT5   = 9;
  localparam int SRC_EXT6   = 10;
  localparam int NUM_SRC    = 11;
  localparam int NUM_LEVELS = 4;

  localparam logic [15:0] VECTOR_TABLE [0:NUM_SRC-1] = '{
    16'h0003, 16'h0083, 16'h000B, 16'h004B, 16'h0013, 16'h0053,
    16'h001B, 16'h005B, 16'h0023, 16'h0063, 16'h006B};

  typedef struct packed {
    logic        valid;
    logic [3:0]  src;
    logic [1:0]  level;
    logic [15:0] vector;
  } eip_irq_req_s;

  // ==========================================================================
  // helpers
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr, input logic wr,
                                     input logic wval);
    flag_next = set | (wr ? wval : (cur & ~clr));
  endfunction

  function automatic logic [1:0] group_level(input int idx, input logic [7:0] lo,
                                             input logic [7:0] hi);
    int g;
    g = idx / 2;
    group_level = {hi[g], lo[g]};
  endfunction

endpackage

// ---- rtl/eip_sync_edge.sv ----
`timescale 1ns/1ps

module eip_sync_edge #(
  parameter int           W    = 1,
  parameter bit           SYNC = 1'b1,
  parameter logic [W-1:0] IDLE = '0
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  // sampled lines
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  // ==========================================================================
  // two stages for pins, one stage for on-chip lines
  always_comb begin
    meta_nxt = d_i;
    lvl_nxt  = SYNC ? meta_r : d_i;
    prev_nxt = lvl_r;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_r <= IDLE;
      lvl_r  <= IDLE;
      prev_r <= IDLE;
    end else begin
      meta_r <= meta_nxt;
      lvl_r  <= lvl_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign lvl_o  = lvl_r;
  assign rise_o = lvl_r & ~prev_r;
  assign fall_o = ~lvl_r & prev_r;

endmodule // eip_sync_edge

// ---- test/eip_core_model.sv ----
`timescale 1ns/1ps
module eip_core_model (
  // clock and reset
  input wire logic             ref_clk_i,
  input wire logic             reset_i,
  // request in, acknowledge out
  input wire logic             slow_i,
  input eip_pkg::eip_irq_req_s req_i,
  output logic                 ack_o
);
  logic [2:0] wait_r;
  // one-cycle ack from a falling edge; slow mode lets a request stand eight cycles
  always @(negedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_o <= '0;
      wait_r <= '0;
    end else begin
      ack_o <= !ack_o && req_i.valid && (!slow_i || wait_r == 3'h7);
      wait_r <= req_i.valid ? wait_r + 3'h1 : 3'h0;
    end
  end
endmodule // eip_core_model

// ---- test/eip_ctrl_sva.sv ----
`timescale 1ns/1ps
module eip_ctrl_sva (
  // clock and reset
  input wire logic                           ref_clk_i,
  input wire logic                           reset_i,
  // sfr access
  input wire logic                           sfr_wr_i,
  input wire logic                           sfr_rd_i,
  input wire logic [7:0]                     sfr_addr_i,
  input wire logic [7:0]                     sfr_wdata_i,
  input wire logic [7:0]                     sfr_rdata_o,
  // core handshake and wake
  input eip_pkg::eip_irq_req_s               irq_req_o,
  input wire logic                           irq_ack_i,
  input wire logic [eip_pkg::NUM_SRC-1:0]    irq_ack_src_o,
  input wire logic [eip_pkg::NUM_LEVELS-1:0] in_service_o,
  input wire logic                           stop_i,
  input wire logic                           wake_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_take;
    irq_ack_i && irq_req_o.valid;
  endsequence
  sequence s_hi_wr_rd;
    sfr_wr_i && sfr_addr_i == 8'hB9 ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hB9;
  endsequence
  chk_ack_drop: assert property (s_take |=> !irq_req_o.valid) else $error("no drop");
  chk_ack_source: assert property (s_take |-> irq_ack_src_o == 11'h1 << irq_req_o.src)
    else $error("bad ack source");
  chk_no_preempt: assert property (irq_req_o.valid |-> (in_service_o >> irq_req_o.level) == 4'h0)
    else $error("bad preempt");
  chk_vec_ext2: assert property (irq_req_o.valid && irq_req_o.src == 4'h3
    |-> irq_req_o.vector == 16'h004B) else $error("bad vector");
  chk_vec_ext0: assert property (irq_req_o.valid && irq_req_o.src == 4'h0
    |-> irq_req_o.vector == 16'h0003) else $error("bad vector");
  chk_flag_gaps: assert property (sfr_rd_i && sfr_addr_i == 8'hC0
    |=> (sfr_rdata_o & 8'hC1) == 8'h00) else $error("bad flag bits");
  chk_prio_back: assert property (s_hi_wr_rd
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'h3F)) else $error("bad readback");
  chk_wake_stop: assert property (!stop_i |=> !wake_o) else $error("bad wake");
endmodule // eip_ctrl_sva

bind eip_ctrl eip_ctrl_sva u_sva (.*);

// ---- test/eip_ctrl_tb.sv ----
`timescale 1ns/1ps
module eip_ctrl_tb;
  logic ref_clk_i = '0, reset_i = '1, sfr_wr_i = '0, sfr_rd_i = '0, reti_i = '0, stop_i = '0;
  logic ext2_pin_i = '1, ext3_pin_i = '1, slow = '1, irq_ack_i, wake_o;
  logic tmr0_flag_i = '0, tmr1_flag_i = '0, ser0_flag_i = '0, ser1_flag_i = '0;
  logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, user_io_pins_i = '0, user_io_hi_sel_i = '0;
  logic [7:0] user_io_lo_sel_i = '0, user_io_pol_i = '0, card_evt_i = '0, card_mask_i = '0;
  logic [2:0] host_evt_i = '0, misc_evt_i = '0, host_mask_i = '0, misc_mask_i = '0;
  logic [2:0] src_flag_rd_i = '0, host_flags_o, misc_flags_o;
  logic [7:0] sfr_rdata_o, card_flags_o;
  logic [10:0] irq_ack_src_o;
  logic [3:0] in_service_o;
  eip_pkg::eip_irq_req_s irq_req_o;
  int bad_count = 0, check_count = 0;
  logic [7:0] wa [6] = '{8'hC8, 8'hA9, 8'hB9, 8'hB8, 8'hC0, 8'h00};
  logic [7:0] we [6] = '{8'h60, 8'h7F, 8'h3F, 8'h7E, 8'h3E, 8'h00};
  logic [15:0] cfg [6] = '{16'hA902, 16'hB902, 16'hC840, 16'hC000, 16'hA880, 16'hB806};
  eip_ctrl u_dut (.*);
  eip_core_model u_core (.ref_clk_i, .reset_i, .slow_i(slow), .req_i(irq_req_o), .ack_o(irq_ack_i));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic xfer(input logic [1:0] wr_rd, input logic [7:0] a, input logic [7:0] d);
    {sfr_wr_i, sfr_rd_i} = wr_rd;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    @(negedge ref_clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    xfer(2'h1, a, 8'h00);
    chk($sformatf("sfr %h", a), 16'(sfr_rdata_o), 16'(exp));
    xfer(2'h0, a, 8'h00);
  endtask
  task automatic wait_req(input logic v);
    for (int n = 0; n < 40 && irq_req_o.valid !== v; n++) @(negedge ref_clk_i);
    chk("valid", 16'(irq_req_o.valid), 16'(v));
  endtask
  task automatic evt(input logic [13:0] v);
    {card_evt_i, host_evt_i, misc_evt_i} = v;
    repeat (6) @(negedge ref_clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(negedge ref_clk_i);
    reset_i = '0;
    foreach (wa[i]) rd_chk(wa[i], 8'h00);
    foreach (wa[i]) begin
      xfer(2'h2, wa[i], 8'hFF);
      rd_chk(wa[i], we[i]);
    end
    chk("valid", 16'(irq_req_o.valid), 16'h0000);
    foreach (cfg[i]) begin
      xfer(2'h2, cfg[i][15:8], cfg[i][7:0]);
      xfer(2'h0, 8'h00, 8'h00);
    end
    ext3_pin_i = '0;
    ext2_pin_i = '0;
    wait_req(1'b1);
    chk("vector", irq_req_o.vector, 16'h004B);
    chk("level", 16'(irq_req_o.level), 16'h0003);
    rd_chk(8'hC0, 8'h02);
    wait_req(1'b0);
    rd_chk(8'hC0, 8'h00);
    chk("in service", 16'(in_service_o), 16'h0008);
    ext3_pin_i = '1;
    repeat (6) @(negedge ref_clk_i);
    chk("valid", 16'(irq_req_o.valid), 16'h0000);
    rd_chk(8'hC0, 8'h04);
    reti_i = '1;
    @(negedge ref_clk_i);
    reti_i = '0;
    wait_req(1'b1);
    chk("vector", irq_req_o.vector, 16'h0053);
    slow <= '0;
    wait_req(1'b0);
    evt(14'h0054);
    chk("masked", {2'h0, card_flags_o, host_flags_o, misc_flags_o}, 16'h0054);
    rd_chk(8'hC0, 8'h00);
    evt(14'h0000);
    {card_mask_i, host_mask_i, misc_mask_i} = '1;
    evt(14'h0054);
    chk("flags", {2'h0, card_flags_o, host_flags_o, misc_flags_o}, 16'h0054);
    rd_chk(8'hC0, 8'h38);
    src_flag_rd_i = 3'h7;
    @(negedge ref_clk_i);
    src_flag_rd_i = 3'h0;
    chk("cleared", {2'h0, card_flags_o, host_flags_o, misc_flags_o}, 16'h0000);
    xfer(2'h2, 8'hA8, 8'h81);
    xfer(2'h0, 8'h00, 8'h00);
    {reti_i, stop_i, user_io_hi_sel_i[0], user_io_pins_i[0]} = '1;
    @(negedge ref_clk_i);
    reti_i = '0;
    wait_req(1'b1);
    chk("vector", irq_req_o.vector, 16'h0003);
    chk("wake", 16'(wake_o), 16'h0001);
    user_io_pol_i = 8'h01;
    repeat (6) @(negedge ref_clk_i);
    chk("wake", 16'(wake_o), 16'h0000);
    // edge mode latches the fall; the lower index wins a level tie
    tmr1_flag_i = '1;
    xfer(2'h2, 8'h88, 8'h01);
    xfer(2'h2, 8'hA8, 8'h89);
    xfer(2'h0, 8'h00, 8'h00);
    {stop_i, user_io_pol_i} = '0;
    repeat (4) @(negedge ref_clk_i);
    chk("wake", 16'(wake_o), 16'h0000);
    user_io_pol_i = 8'h01;
    repeat (3) @(negedge ref_clk_i);
    rd_chk(8'h88, 8'h03);
    reti_i = '1;
    @(negedge ref_clk_i);
    reti_i = '0;
    wait_req(1'b1);
    chk("vector", irq_req_o.vector, 16'h0003);
    wait_req(1'b0);
    rd_chk(8'h88, 8'h01);
    end_sim();
  end
endmodule // eip_ctrl_tb
